// ### common/adcsp_map.vh
// Constants of the converter serial data port.
// Assumes inclusion by bare name from the rtl files; definitions only.
`ifndef ADCSP_MAP_VH
`define ADCSP_MAP_VH

// ==========================================================
// Interface options, caught once after reset
`define ADCSP_MODE_SPI 2'h0
`define ADCSP_MODE_FSM 2'h1
`define ADCSP_MODE_FSS 2'h2

// ==========================================================
// SPI clocking: idle low, launch on rising, capture on falling
`define ADCSP_CPOL 1'h0
`define ADCSP_CPHA 1'h1

// ==========================================================
// Word and frame shape
`define ADCSP_WORD_BITS 24
`define ADCSP_FRAME_SCLKS 32
`define ADCSP_FS_HALF_SCLKS 16
`define ADCSP_FIFO_DEPTH 8

// ==========================================================
// Timing, in master clock periods except ADCSP_CLK_NS in ns; clk_sys is the master clock
`define ADCSP_CLK_NS 10
`define ADCSP_TOUT_LONG_TCLK 65536
`define ADCSP_TOUT_SHORT_TCLK 16384
`define ADCSP_TOUT_CYCLES(t) (t)
`define ADCSP_SCLK_HALF_CYCLES 2

// ==========================================================
// Input synchroniser bit positions
`define ADCSP_SY_CS 0
`define ADCSP_SY_SCLK 1
`define ADCSP_SY_FS 2
`define ADCSP_SY_CHAIN 3
`define ADCSP_SY_TOUT 4
`define ADCSP_SY_MODE 5
`define ADCSP_SY_BITS 7

`endif

// ### rtl/adcsp_fifo.v
// Word FIFO between the conversion source and the serial shifter.
// Assumes one clock, asynchronous active-low reset; storage in flip-flops.
module adcsp_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire doWrite;
  wire doRead;

  assign inReady = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData = mem_r[rdPtr_r];
  assign doWrite = inValid & inReady;
  assign doRead = outReady & outValid;

  // ==========================================================
  // Pointers and fill level
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (doWrite)
        wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
      if (doRead)
        rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
      if (doWrite && !doRead)
        count_r <= count_r + 1'b1;
      else if (doRead && !doWrite)
        count_r <= count_r - 1'b1;
    end
  end

  // ==========================================================
  // Storage; no reset needed, reads are gated by outValid
  always @(posedge clk_sys) begin
    if (doWrite)
      mem_r[wrPtr_r] <= inData;
  end

endmodule

// ### rtl/adcsp_port.v
// Serial data output port of a delta-sigma converter: SPI slave,
// frame-sync master and frame-sync slave, each with daisy-chain input.
// Assumes clk_sys is the converter master clock; all pins are asynchronous.
// Summary of operation
// - SPI uses polarity zero, phase one: clock idles low, host captures on falling.
// - SPI: data line driven only after chip select falls.
// - SPI: data line released to high impedance after chip select rises.
// - SPI: new bit launched after rising clock, held past next falling edge.
// - Master: frame sync period is one data period, half high, half low.
// - Master: serial clock is 32 times data rate, 50 percent duty.
// - Master: serial clock derived from master clock, falls after its rising edge.
// - Master: frame sync rises on the same master clock edge as a serial clock fall.
// - Master: most significant bit presented when frame sync rises.
// - Master: later bits shift after clock fall, valid past next rising edge.
// - Slave: chain input sampled on serial clock rising edges.
// - Slave: bits launch after clock fall, MSB after frame sync rises.
// - SPI: abort unfinished transfer after 2^16 or 2^14 master clocks.
// - SPI daisy chain: chain input sampled on serial clock falling edges.
`include "adcsp_map.vh"

module adcsp_port #(
  parameter WORD_BITS = `ADCSP_WORD_BITS,
  parameter FIFO_DEPTH = `ADCSP_FIFO_DEPTH,
  parameter SCLK_HALF = `ADCSP_SCLK_HALF_CYCLES,
  parameter TOUT_LONG = `ADCSP_TOUT_CYCLES(`ADCSP_TOUT_LONG_TCLK),
  parameter TOUT_SHORT = `ADCSP_TOUT_CYCLES(`ADCSP_TOUT_SHORT_TCLK)
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [1:0] modeCfg,
  input wire timeoutSelect,
  input wire csN,
  input wire sclkIn,
  input wire frameSyncIn,
  input wire chainIn,
  input wire [WORD_BITS-1:0] wordData,
  input wire wordValid,
  output wire wordReady,
  output wire doutO,
  output wire doutOe,
  output wire sclkO,
  output wire sclkOe,
  output wire frameSyncO,
  output wire frameSyncOe,
  output wire [1:0] modeActive,
  output wire xferActive,
  output wire timeoutFlag,
  output wire underrunFlag
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_ABORT = 2'h2;

  reg [`ADCSP_SY_BITS-1:0] syncA_r;
  reg [`ADCSP_SY_BITS-1:0] syncB_r;
  reg sclkPrev_r;
  reg csPrev_r;
  reg fsPrev_r;
  reg [1:0] startCnt_r;
  reg [1:0] mode_r;
  reg modeValid_r;

  reg [15:0] halfCnt_r;
  reg sclkGen_r;
  reg [4:0] bitCnt_r;
  reg fsGen_r;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [WORD_BITS-1:0] shift_r;
  reg chainBit_r;
  reg oe_r;
  reg firstEdge_r;
  reg [16:0] toutCnt_r;
  reg timeout_r;
  reg underrun_r;

  reg loadEv;
  reg shiftEv;
  reg sampleEv;
  reg endEv;

  wire csS;
  wire sclkS;
  wire fsS;
  wire chainS;
  wire sclkRise;
  wire sclkFall;
  wire csFall;
  wire csRise;
  wire fsRise;
  wire halfDone;
  wire genFall;
  wire genRise;
  wire [16:0] toutLimit;
  wire toutHit;
  wire fifoValid;
  wire [WORD_BITS-1:0] fifoData;
  wire popReq;

  // ==========================================================
  // Pin synchronisers, two flops per bit
  wire [`ADCSP_SY_BITS-1:0] pinVec;
  assign pinVec = {modeCfg, timeoutSelect, chainIn, frameSyncIn, sclkIn, csN};

  genvar gi;
  generate
    for (gi = 0; gi < `ADCSP_SY_BITS; gi = gi + 1) begin : gSync
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          syncA_r[gi] <= (gi == `ADCSP_SY_CS) ? 1'b1 : 1'b0;
          syncB_r[gi] <= (gi == `ADCSP_SY_CS) ? 1'b1 : 1'b0;
        end else begin
          syncA_r[gi] <= pinVec[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate

  assign csS = syncB_r[`ADCSP_SY_CS];
  assign sclkS = syncB_r[`ADCSP_SY_SCLK];
  assign fsS = syncB_r[`ADCSP_SY_FS];
  assign chainS = syncB_r[`ADCSP_SY_CHAIN];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev_r <= `ADCSP_CPOL;
      csPrev_r <= 1'b1;
      fsPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= sclkS;
      csPrev_r <= csS;
      fsPrev_r <= fsS;
    end
  end

  assign sclkRise = sclkS & ~sclkPrev_r;
  assign sclkFall = ~sclkS & sclkPrev_r;
  assign csFall = ~csS & csPrev_r;
  assign csRise = csS & ~csPrev_r;
  assign fsRise = fsS & ~fsPrev_r;

  // ==========================================================
  // Option strap, caught once the synchronisers have filled
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      startCnt_r <= 2'h0;
      mode_r <= `ADCSP_MODE_SPI;
      modeValid_r <= 1'b0;
    end else if (!modeValid_r) begin
      startCnt_r <= startCnt_r + 2'h1;
      if (startCnt_r == 2'h3) begin
        mode_r <= syncB_r[`ADCSP_SY_MODE+1:`ADCSP_SY_MODE];
        modeValid_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Master clock divider: serial clock and frame sync generation
  // Every edge of the serial clock is a clk_sys flop output, so each
  // falling edge follows a master clock rising edge.
  assign halfDone = (halfCnt_r == SCLK_HALF[15:0] - 16'h1);
  assign genFall = halfDone & sclkGen_r;
  assign genRise = halfDone & ~sclkGen_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt_r <= 16'h0;
      sclkGen_r <= 1'b0;
      bitCnt_r <= 5'h1f;
      fsGen_r <= 1'b0;
    end else if (modeValid_r && mode_r == `ADCSP_MODE_FSM) begin
      halfCnt_r <= halfDone ? 16'h0 : halfCnt_r + 16'h1;
      if (halfDone)
        sclkGen_r <= ~sclkGen_r;
      if (genFall) begin
        bitCnt_r <= bitCnt_r + 5'h1;
        if (bitCnt_r == `ADCSP_FRAME_SCLKS - 1)
          fsGen_r <= 1'b1;
        else if (bitCnt_r == `ADCSP_FS_HALF_SCLKS - 1)
          fsGen_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Per-option event selection
  always @* begin
    loadEv = 1'b0;
    shiftEv = 1'b0;
    sampleEv = 1'b0;
    endEv = 1'b0;
    if (modeValid_r) begin
      case (mode_r)
        `ADCSP_MODE_SPI: begin
          loadEv = csFall;
          shiftEv = sclkRise & ~firstEdge_r & ~csS;
          sampleEv = sclkFall & ~csS;
          endEv = csRise | toutHit;
        end
        `ADCSP_MODE_FSM: begin
          loadEv = genFall & (bitCnt_r == `ADCSP_FRAME_SCLKS - 1);
          shiftEv = genFall & ~loadEv;
          sampleEv = genRise;
        end
        `ADCSP_MODE_FSS: begin
          loadEv = fsRise;
          shiftEv = sclkFall & ~fsRise;
          sampleEv = sclkRise;
        end
        default: begin
          loadEv = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Transfer state and shifter
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (loadEv)
          state_nxt = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (toutHit)
          state_nxt = ST_ABORT;
        else if (endEv)
          state_nxt = ST_IDLE;
      end
      ST_ABORT: begin
        if (csRise)
          state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // A frame start with an empty FIFO sends zeros rather than stale bits.
  assign popReq = loadEv & fifoValid & (state_r != ST_ABORT);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      shift_r <= {WORD_BITS{1'b0}};
      chainBit_r <= 1'b0;
      oe_r <= 1'b0;
      firstEdge_r <= 1'b0;
      underrun_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      underrun_r <= 1'b0;
      if (sampleEv)
        chainBit_r <= chainS;
      if (loadEv && state_r != ST_ABORT) begin
        shift_r <= fifoValid ? fifoData : {WORD_BITS{1'b0}};
        underrun_r <= ~fifoValid;
        oe_r <= 1'b1;
        firstEdge_r <= 1'b1;
      end else if (state_r == ST_SHIFT && shiftEv) begin
        shift_r <= {shift_r[WORD_BITS-2:0], chainBit_r};
      end
      if (sclkRise && !csS && mode_r == `ADCSP_MODE_SPI)
        firstEdge_r <= 1'b0;
      if (mode_r == `ADCSP_MODE_SPI && (csRise || toutHit))
        oe_r <= 1'b0;
    end
  end

  // ==========================================================
  // SPI timeout from chip select fall
  // Counted in clk_sys cycles, which are the master clock periods.
  assign toutLimit = syncB_r[`ADCSP_SY_TOUT] ? TOUT_SHORT[16:0] : TOUT_LONG[16:0];
  assign toutHit = (state_r == ST_SHIFT) && (mode_r == `ADCSP_MODE_SPI) &&
                   (toutCnt_r == toutLimit - 17'h1);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      toutCnt_r <= 17'h0;
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= toutHit;
      if (state_r == ST_SHIFT && mode_r == `ADCSP_MODE_SPI)
        toutCnt_r <= toutCnt_r + 17'h1;
      else
        toutCnt_r <= 17'h0;
    end
  end

  // ==========================================================
  // Word buffer between the converter and the shifter
  adcsp_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) i_adcsp_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inData(wordData),
    .inValid(wordValid),
    .inReady(wordReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(popReq)
  );

  // ==========================================================
  // Outputs
  assign doutO = oe_r & shift_r[WORD_BITS-1];
  assign doutOe = oe_r;
  assign sclkO = sclkGen_r;
  assign sclkOe = modeValid_r & (mode_r == `ADCSP_MODE_FSM);
  assign frameSyncO = fsGen_r;
  assign frameSyncOe = modeValid_r & (mode_r == `ADCSP_MODE_FSM);
  assign modeActive = mode_r;
  assign xferActive = (state_r == ST_SHIFT);
  assign timeoutFlag = timeout_r;
  assign underrunFlag = underrun_r;

endmodule

// ### sim/adcsp_port_properties.sv
// Pin-level assertions for the converter serial port.
// Assumes a bind onto adcsp_port with SCLK_HALF left at 2.
`include "adcsp_map.vh"

module adcsp_port_properties #(
  parameter TOUT_LONG = 65536,
  parameter TOUT_SHORT = 16384
) (
  input wire clk_sys,
  input wire rst_n,
  input wire timeoutSelect,
  input wire csN,
  input wire sclkIn,
  input wire doutO,
  input wire doutOe,
  input wire sclkO,
  input wire sclkOe,
  input wire frameSyncO,
  input wire frameSyncOe,
  input wire [1:0] modeActive,
  input wire timeoutFlag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Helpers
  reg [19:0] lowCnt_r;
  wire spi = modeActive == `ADCSP_MODE_SPI;
  wire fsm = modeActive == `ADCSP_MODE_FSM;
  // Counted from the pin, so it runs ahead of the synchronised copy
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      lowCnt_r <= 20'h0;
    else if (csN)
      lowCnt_r <= 20'h0;
    else if (lowCnt_r != 20'hfffff)
      lowCnt_r <= lowCnt_r + 20'h1;
  end
  sequence sclkLow;
    !sclkO [*2];
  endsequence
  sequence sclkHigh;
    sclkO [*2];
  endsequence
  // ==========================================================
  // Assertions
  oe_after_select_a: assert property (spi && $fell(csN) |-> ##[2:4] doutOe)
    else $error("data line not driven after select");
  oe_idle_a: assert property ((spi && csN) [*5] |-> !doutOe)
    else $error("data line driven while deselected");
  spi_shift_a: assert property (spi && doutOe && $past(doutOe) && $changed(doutO) |-> sclkIn)
    else $error("spi bit changed with clock low");
  timeout_early_a: assert property (timeoutFlag |-> lowCnt_r >= (timeoutSelect ? TOUT_SHORT : TOUT_LONG))
    else $error("timeout too early");
  timeout_late_a: assert property (spi && lowCnt_r == TOUT_LONG + 8 |-> !doutOe)
    else $error("transfer not aborted");
  sclk_cycle_a: assert property (fsm && $fell(sclkO) |-> sclkLow ##1 sclkHigh ##1 $fell(sclkO))
    else $error("master clock shape wrong");
  fs_frame_a: assert property ($rose(frameSyncO) |-> ##64 $fell(frameSyncO) ##64 $rose(frameSyncO))
    else $error("frame sync period wrong");
  master_shift_a: assert property (fsm && $changed(doutO) |-> sclkLow ##1 sclkO && sclkOe && frameSyncOe)
    else $error("master bit changed off clock fall");
  strap_a: assert property (modeActive != `ADCSP_MODE_SPI |=> $stable(modeActive))
    else $error("option changed in operation");
endmodule

// ### sim/adcsp_host.sv
// Host model: select, serial clock, frame sync and chain data.
// Assumes a 100 MHz master clock; a serial clock half is 8 periods.
module adcsp_host (
  input wire clk_sys,
  input wire doutO,
  input wire doutOe,
  input wire sclkO,
  input wire frameSyncO,
  output logic csN,
  output logic sclkIn,
  output logic frameSyncIn,
  output logic chainIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lastV = 1'b0;
  // Released line must not pass for held data
  wire lineV = doutOe ? doutO : ~lastV;
  always @(posedge clk_sys) lastV <= lineV;
  initial begin
    csN = 1'b1;
    sclkIn = 1'b0;
    frameSyncIn = 1'b0;
    chainIn = 1'b1;
  end
  task automatic half();
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic spiRead(output logic [31:0] w);
    csN = 1'b0;
    half();
    for (int i = 0; i < 32; i++) begin
      sclkIn = 1'b1;
      half();
      w = {w[30:0], lineV};
      sclkIn = 1'b0;
      half();
    end
    csN = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic spiHold(input int n);
    csN = 1'b0;
    repeat (n) @(negedge clk_sys);
    csN = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic fsCapture(output logic [31:0] w);
    @(posedge frameSyncO);
    for (int i = 0; i < 32; i++) begin
      @(posedge sclkO);
      w = {w[30:0], lineV};
    end
  endtask
  task automatic fsFrame(output logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      sclkIn = 1'b0;
      frameSyncIn = (i < 16);
      half();
      sclkIn = 1'b1;
      w = {w[30:0], lineV};
      half();
    end
  endtask
endmodule

// ### sim/adc_serial_data_port_bench.sv
// Self-checking bench for the serial port in all three options.
// Assumes adcsp_host on the far side and the checker bound below.
`include "adcsp_map.vh"
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t %s", $time, m); end end

module adc_serial_data_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened so a timeout fits in the run
  localparam int TL = 800;
  localparam int TS = 200;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] modeCfg = 2'h0;
  logic timeoutSelect = 1'b0;
  logic [23:0] wordData = 24'h0;
  logic wordValid = 1'b0;
  int nUnder = 0;
  logic [31:0] w;
  int n_fail = 0;
  int check_count = 0;
  wire csN, sclkIn, frameSyncIn, chainIn, wordReady, doutO, doutOe, sclkO, sclkOe;
  wire frameSyncO, frameSyncOe, xferActive, timeoutFlag, underrunFlag;
  wire [1:0] modeActive;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (underrunFlag === 1'b1) nUnder <= nUnder + 1;
  adcsp_port #(.TOUT_LONG(TL), .TOUT_SHORT(TS)) i_adcsp_port (
    .clk_sys, .rst_n, .modeCfg, .timeoutSelect, .csN, .sclkIn, .frameSyncIn, .chainIn, .wordData,
    .wordValid, .wordReady, .doutO, .doutOe, .sclkO, .sclkOe, .frameSyncO, .frameSyncOe, .modeActive,
    .xferActive, .timeoutFlag, .underrunFlag);
  adcsp_host i_adcsp_host (.clk_sys, .doutO, .doutOe, .sclkO, .frameSyncO, .csN, .sclkIn, .frameSyncIn, .chainIn);
  // ==========================================================
  // Shared steps
  function automatic logic [23:0] pat(input int i);
    return {i[3:0], 20'ha5c3e} ^ {24{i[0]}};
  endfunction
  task automatic push(input logic [23:0] d);
    wordData = d;
    wordValid = 1'b1;
    @(negedge clk_sys);
    wordValid = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic doReset(input logic [1:0] m);
    rst_n = 1'b0;
    modeCfg = m;
    repeat (5) @(negedge clk_sys);
    `CHK({doutOe, sclkOe, frameSyncOe, xferActive, wordReady}, 5'h1, "reset values")
    rst_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK(modeActive, m, "option caught")
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_spi();
    int u0;
    doReset(`ADCSP_MODE_SPI);
    for (int i = 0; i < 8; i++) push(pat(i));
    `CHK(wordReady, 1'b0, "fifo not full")
    push(24'hffffff);
    for (int i = 0; i < 8; i++) begin
      i_adcsp_host.spiRead(w);
      `CHK({w[31:8], w[6:0]}, {pat(i), 7'h7f}, "spi word")
    end
    u0 = nUnder;
    i_adcsp_host.spiRead(w);
    `CHK(w[31:8], 24'h0, "empty read")
    `CHK(nUnder - u0, 1, "one underrun pulse")
    $display("spi test done");
  endtask
  task automatic t_timeout();
    int n;
    int lim;
    for (int s = 1; s >= 0; s--) begin
      timeoutSelect = s[0];
      lim = s ? TS : TL;
      repeat (4) @(negedge clk_sys);
      n = 0;
      fork
        i_adcsp_host.spiHold(TL + 20);
        begin
          while (timeoutFlag !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
          end
          repeat (2) @(negedge clk_sys);
          `CHK(doutOe, 1'b0, "not released")
          `CHK(xferActive, 1'b0, "transfer not aborted")
        end
      join
      `CHK(n >= lim && n <= lim + 8, 1'b1, "timeout span")
    end
    $display("timeout test done");
  endtask
  task automatic t_master();
    doReset(`ADCSP_MODE_FSM);
    push(pat(9));
    push(pat(10));
    for (int i = 9; i < 11; i++) begin
      i_adcsp_host.fsCapture(w);
      `CHK({w[31:8], w[6:0]}, {pat(i), 7'h7f}, "master word")
    end
    $display("master test done");
  endtask
  task automatic t_slave();
    doReset(`ADCSP_MODE_FSS);
    push(pat(11));
    push(pat(12));
    for (int i = 11; i < 13; i++) begin
      i_adcsp_host.fsFrame(w);
      `CHK({w[31:8], w[6:0]}, {pat(i), 7'h7f}, "slave word")
    end
    $display("slave test done");
  endtask
  initial begin
    t_spi();
    t_timeout();
    t_master();
    t_slave();
    summarize();
  end
  initial begin
    #200us;
    n_fail++;
    $display("MISMATCH %0t watchdog", $time);
    summarize();
  end
endmodule

bind adcsp_port adcsp_port_properties #(.TOUT_LONG(TOUT_LONG), .TOUT_SHORT(TOUT_SHORT)) i_adcsp_port_properties (
  .clk_sys, .rst_n, .timeoutSelect, .csN, .sclkIn, .doutO, .doutOe, .sclkO, .sclkOe, .frameSyncO,
  .frameSyncOe, .modeActive, .timeoutFlag);
